/* File: bench/dfss_status_bank_assertions.sv */
// Port checker for the status bank
// Bound to dfss_status_bank; one clock, synchronous reset
`timescale 1ns/1ps
module dfss_status_bank_assertions #(
  parameter int FREQ_WIDTH = 24,
  parameter int INPUTS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [INPUTS-1:0] no_alarm,
  input wire logic [INPUTS-1:0] soft_alarm_only,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence s_rd; avs_read && avs_waitrequest; endsequence
  sequence s_ans; (avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest; endsequence
  property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_idle; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("wait while idle");
  property p_back; s_ans |=> avs_waitrequest == (avs_read || avs_write); endproperty
  a_back: assert property (p_back) else $error("not idle after answer");
  // Reset edge guard: the validity register is cleared there, not loaded
  property p_valid;
    s_rd ##0 (avs_address == 6'h0c && !$past(reset)) |=>
      avs_readdata[7:0] == ($past(no_alarm, 2) | $past(soft_alarm_only, 2));
  endproperty
  a_valid: assert property (p_valid) else $error("validity byte wrong");
  property p_unmap; s_rd ##0 avs_address > 6'h18 |=> avs_response == 2'h2 && avs_readdata == 0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped answer wrong");
  property p_ok; s_rd ##0 (avs_address <= 6'h18 && avs_address[1:0] == 2'h0) |=> !avs_response;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped read refused");
  property p_hold; !(avs_read || avs_write) |=> $stable(avs_readdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rst; $past(reset) |-> !irq && avs_readdata == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule

bind dfss_status_bank dfss_status_bank_assertions #(.FREQ_WIDTH(FREQ_WIDTH), .INPUTS(INPUTS))
  u_chk (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .avs_response, .no_alarm, .soft_alarm_only, .irq);

/* File: bench/tb.sv */
// Self-checking bench: readout, validity, freeze, interrupt, unmapped access
// Assumes the checker binds itself to the bank
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq;
  logic [1:0] avs_response;
  logic [23:0] main_integral = 24'h0, secondary_integral = 24'h0, fz;
  logic [7:0] no_alarm = 8'hff, soft_alarm_only = 8'h00;
  int n_fail = 0;
  int samples_checked = 0;
  dfss_status_bank u_dfss_status_bank (.clk, .reset, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .avs_response,
    .main_integral, .secondary_integral, .no_alarm, .soft_alarm_only, .irq);
  initial begin
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // Request stands until waitrequest is seen low at a rising edge; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    rd = avs_readdata;
    check({29'h0, avs_waitrequest, avs_response}, {30'h0, a > 6'h18, 1'b0});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [23:0] pick(input logic p, input logic [23:0] m, s);
    return p ? m : s;
  endfunction
  task automatic read_freq(input logic [23:0] v);
    for (int j = 0; j < 3; j++) begin
      bus(1'b0, 6'(4 * j), 32'h0);
      check(rd, {24'h0, v[8*j +: 8]});
    end
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    check({31'h0, irq}, {31'h0, e});
    @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    logic p;
    void'($urandom(34998));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    bus(1'b0, 6'h0c, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 6'h0c, 32'h0);
    check(rd, 32'hff);
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      p = i < 2 ? i == 0 : 1'($urandom);
      main_integral <= i == 0 ? 24'h800000 : 24'($urandom);
      secondary_integral <= i == 1 ? 24'h7fffff : 24'($urandom);
      no_alarm <= 8'($urandom);
      soft_alarm_only <= i < 2 ? 8'h00 : 8'($urandom);
      bus(1'b1, 6'h10, {27'h0, p, 4'h0});
      bus(1'b1, 6'h0c, 32'hffffffff);
      bus(1'b1, 6'h08, 32'($urandom));
      read_freq(pick(p, main_integral, secondary_integral));
      bus(1'b0, 6'h0c, 32'h0);
      check(rd, {24'h0, no_alarm | soft_alarm_only});
    end
    $display("readout test done");
    fz = pick(p, main_integral, secondary_integral);
    bus(1'b1, 6'h10, 32'h18);
    main_integral <= ~main_integral;
    secondary_integral <= ~secondary_integral;
    read_freq(fz);
    bus(1'b1, 6'h10, 32'h10);
    read_freq(main_integral);
    $display("freeze test done");
    no_alarm <= 8'h5a;
    soft_alarm_only <= 8'h00;
    bus(1'b1, 6'h18, 32'h2);
    bus(1'b1, 6'h14, 32'h3);
    chk_irq(1'b0);
    no_alarm <= 8'ha5;
    repeat (2) @(posedge clk);
    chk_irq(1'b1);
    bus(1'b1, 6'h18, 32'h0);
    chk_irq(1'b0);
    bus(1'b1, 6'h18, 32'h2);
    chk_irq(1'b1);
    bus(1'b1, 6'h14, 32'h2);
    chk_irq(1'b0);
    $display("irq test done");
    bus(1'b0, 6'h3c, 32'h0);
    check(rd, 32'h0);
    $display("unmapped test done");
    complete_run;
  end
endmodule

/* File: logic/dfss_defs.svh */
// Offsets, field positions, reset values and scale figures of the frequency and validity status bank
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per aligned word
`ifndef DFSS_DEFS_SVH
`define DFSS_DEFS_SVH

// Register word addresses (byte offsets)
`define DFSS_OFF_FREQ_LOW 6'h00
`define DFSS_OFF_FREQ_MID 6'h04
`define DFSS_OFF_FREQ_HIGH 6'h08
`define DFSS_OFF_VALID_LOW 6'h0c
`define DFSS_OFF_CONTROL 6'h10
`define DFSS_OFF_IRQ_STATUS 6'h14
`define DFSS_OFF_IRQ_MASK 6'h18

// Control fields
`define DFSS_CTL_FREEZE_BIT 3
`define DFSS_CTL_PATH_BIT 4
`define DFSS_CTL_RESET 8'h00

// Interrupt status bits
`define DFSS_IRQ_FREQ_BIT 0
`define DFSS_IRQ_VALID_BIT 1
`define DFSS_IRQ_WIDTH 2

`define DFSS_VALID_RESET 8'h00
`define DFSS_FREQ_RESET 24'h000000

// One unit of the readout is this many ppm, times ten to the seven
`define DFSS_PPM_PER_LSB_E7 3068

`endif

/* File: logic/dfss_freq_capture.sv */
// Holds the reported integral-path frequency, chosen from the main or secondary path
// Assumes both path values arrive already as signed integral-path words on clk
`timescale 1ns/1ps
`include "dfss_defs.svh"
module dfss_freq_capture
  import dfss_pkg::*;
#(
  parameter int FREQ_WIDTH = 24
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [FREQ_WIDTH-1:0] main_integral,
  input wire logic [FREQ_WIDTH-1:0] secondary_integral,
  dfss_snap_if.capture snap
);
  logic [FREQ_WIDTH-1:0] freq_reg;
  logic [FREQ_WIDTH-1:0] freq_next;
  logic changed_reg;
  logic changed_next;

  always_comb begin
    freq_next = freq_reg;
    changed_next = 1'b0;
    if (!snap.freeze) begin
      // Integral path only: smoothing comes from the loop, not from here
      freq_next = snap.path_main ? main_integral : secondary_integral;
      changed_next = (freq_next != freq_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      freq_reg <= FREQ_WIDTH'(`DFSS_FREQ_RESET);
      changed_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      changed_reg <= changed_next;
    end
  end

  assign snap.freq_value = freq_reg;
  assign snap.freq_changed = changed_reg;
endmodule

/* File: logic/dfss_pkg.sv */
// Types shared by the frequency and validity status bank
// Assumes dfss_defs.svh is compiled alongside
package dfss_pkg;
  typedef enum logic [1:0] {
    DFSS_BUS_IDLE = 2'b00,
    DFSS_BUS_ANSWER = 2'b01
  } dfss_bus_state_t;

  typedef logic signed [23:0] dfss_freq_t;
endpackage

/* File: logic/dfss_snap_if.sv */
// Carrier between the top bank and its capture and validity sub-blocks
// Assumes one clock, owned by the top module
`timescale 1ns/1ps
interface dfss_snap_if #(parameter int FREQ_WIDTH = 24, parameter int INPUTS = 8);
  logic [FREQ_WIDTH-1:0] freq_value;
  logic freq_changed;
  logic [INPUTS-1:0] valid_bits;
  logic valid_changed;
  logic freeze;
  logic path_main;

  modport capture (input freeze, input path_main, output freq_value, output freq_changed);
  modport validity (output valid_bits, output valid_changed);
  modport bank (input freq_value, input freq_changed, input valid_bits, input valid_changed,
    output freeze, output path_main);
endinterface

/* File: logic/dfss_status_bank.sv */
// Frequency offset and input validity status bank with Avalon-MM slave and interrupt
// Assumes a single 25 MHz clock, synchronous reset, master that holds requests
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "dfss_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Frequency readout is signed 24-bit, three bytes
// - Readout times 0.0003068 gives ppm offset
// - Reported value is DPLL integral path
// - Freeze control bit stops readout updates
// - Path bit selects main clock path report
// - Validity bit high: no alarm or soft
// - Validity byte read-only, zero after reset
module dfss_status_bank
  import dfss_pkg::*;
#(
  parameter int FREQ_WIDTH = 24,
  parameter int INPUTS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [FREQ_WIDTH-1:0] main_integral,
  input wire logic [FREQ_WIDTH-1:0] secondary_integral,
  input wire logic [INPUTS-1:0] no_alarm,
  input wire logic [INPUTS-1:0] soft_alarm_only,
  output logic irq
);
  dfss_snap_if #(.FREQ_WIDTH(FREQ_WIDTH), .INPUTS(INPUTS)) snap();

  dfss_freq_capture #(.FREQ_WIDTH(FREQ_WIDTH)) u_capture (
    .clk(clk),
    .reset(reset),
    .main_integral(main_integral),
    .secondary_integral(secondary_integral),
    .snap(snap)
  );

  dfss_validity #(.INPUTS(INPUTS)) u_validity (
    .clk(clk),
    .reset(reset),
    .no_alarm(no_alarm),
    .soft_alarm_only(soft_alarm_only),
    .snap(snap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus state and registers

  dfss_bus_state_t state_reg;
  dfss_bus_state_t state_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0] resp_reg;
  logic [1:0] resp_next;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [`DFSS_IRQ_WIDTH-1:0] irq_status_reg;
  logic [`DFSS_IRQ_WIDTH-1:0] irq_status_next;
  logic [`DFSS_IRQ_WIDTH-1:0] irq_mask_reg;
  logic [`DFSS_IRQ_WIDTH-1:0] irq_mask_next;
  logic [`DFSS_IRQ_WIDTH-1:0] irq_events;
  logic [31:0] freq_word;
  logic [31:0] read_mux;
  logic mapped;
  logic request;

  function automatic logic is_mapped(input logic [5:0] addr);
    case (addr)
      `DFSS_OFF_FREQ_LOW,
      `DFSS_OFF_FREQ_MID,
      `DFSS_OFF_FREQ_HIGH,
      `DFSS_OFF_VALID_LOW,
      `DFSS_OFF_CONTROL,
      `DFSS_OFF_IRQ_STATUS,
      `DFSS_OFF_IRQ_MASK: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  // Sign-extend to 32 bits; each byte-lane read below returns only 8 bits of it, zero-padded
  always_comb begin
    freq_word = {{(32 - FREQ_WIDTH){snap.freq_value[FREQ_WIDTH-1]}}, snap.freq_value};
  end

  always_comb begin
    read_mux = 32'h00000000;
    case (avs_address)
      // Byte lanes of the signed readout; one lsb is 0.0003068 ppm
      `DFSS_OFF_FREQ_LOW: read_mux = {24'h000000, freq_word[7:0]};
      `DFSS_OFF_FREQ_MID: read_mux = {24'h000000, freq_word[15:8]};
      `DFSS_OFF_FREQ_HIGH: read_mux = {24'h000000, freq_word[23:16]};
      `DFSS_OFF_VALID_LOW: read_mux = 32'(snap.valid_bits);
      `DFSS_OFF_CONTROL: read_mux = {24'h000000, ctl_reg};
      `DFSS_OFF_IRQ_STATUS: read_mux = 32'(irq_status_reg);
      `DFSS_OFF_IRQ_MASK: read_mux = 32'(irq_mask_reg);
      default: read_mux = 32'h00000000;
    endcase
  end

  assign request = avs_read | avs_write;
  assign mapped = is_mapped(avs_address);

  always_comb begin
    irq_events = '0;
    irq_events[`DFSS_IRQ_FREQ_BIT] = snap.freq_changed;
    irq_events[`DFSS_IRQ_VALID_BIT] = snap.valid_changed;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    resp_next = resp_reg;
    ctl_next = ctl_reg;
    irq_mask_next = irq_mask_reg;
    irq_status_next = irq_status_reg;
    case (state_reg)
      DFSS_BUS_IDLE: begin
        if (request) begin
          state_next = DFSS_BUS_ANSWER;
          resp_next = mapped ? 2'h0 : 2'h2;
          rdata_next = avs_read ? read_mux : 32'h00000000;
        end
      end
      DFSS_BUS_ANSWER: begin
        state_next = DFSS_BUS_IDLE;
        // The transfer completes at this edge, so a write lands here and nowhere earlier
        // Frequency and validity words have no write path at all
        if (avs_write && avs_byteenable[0]) begin
          case (avs_address)
            `DFSS_OFF_CONTROL: ctl_next = avs_writedata[7:0];
            `DFSS_OFF_IRQ_MASK: irq_mask_next = avs_writedata[`DFSS_IRQ_WIDTH-1:0];
            `DFSS_OFF_IRQ_STATUS:
              irq_status_next = irq_status_reg & ~avs_writedata[`DFSS_IRQ_WIDTH-1:0];
            default: ctl_next = ctl_reg;
          endcase
        end
      end
      default: state_next = DFSS_BUS_IDLE;
    endcase
    // A new event wins over a clear in the same cycle
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= DFSS_BUS_IDLE;
      rdata_reg <= 32'h00000000;
      resp_reg <= 2'h0;
      ctl_reg <= `DFSS_CTL_RESET;
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      state_reg <= state_next;
      rdata_reg <= rdata_next;
      resp_reg <= resp_next;
      ctl_reg <= ctl_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign snap.freeze = ctl_reg[`DFSS_CTL_FREEZE_BIT];
  assign snap.path_main = ctl_reg[`DFSS_CTL_PATH_BIT];

  // Request is answered one cycle after it is taken into the idle state
  assign avs_waitrequest = request & (state_reg != DFSS_BUS_ANSWER);
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;
  assign irq = |(irq_status_reg & irq_mask_reg);
endmodule

/* File: logic/dfss_validity.sv */
// Registers the per-input validity flags from the input monitors
// Assumes no-alarm and soft-frequency-alarm-only flags per input, synchronous to clk
`timescale 1ns/1ps
`include "dfss_defs.svh"
module dfss_validity
  import dfss_pkg::*;
#(
  parameter int INPUTS = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [INPUTS-1:0] no_alarm,
  input wire logic [INPUTS-1:0] soft_alarm_only,
  dfss_snap_if.validity snap
);
  logic [INPUTS-1:0] valid_reg;
  logic [INPUTS-1:0] valid_next;
  logic changed_reg;
  logic changed_next;

  genvar g;
  generate
    for (g = 0; g < INPUTS; g++) begin : g_in
      always_comb begin
        valid_next[g] = no_alarm[g] | soft_alarm_only[g];
      end
    end
  endgenerate

  always_comb begin
    changed_next = (valid_next != valid_reg);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      valid_reg <= INPUTS'(`DFSS_VALID_RESET);
      changed_reg <= 1'b0;
    end else begin
      valid_reg <= valid_next;
      changed_reg <= changed_next;
    end
  end

  assign snap.valid_bits = valid_reg;
  assign snap.valid_changed = changed_reg;
endmodule
